//--- hdl/atpam_pkg.sv
// Constants and types for the amplifier-trim and pump-alarm register bank.
// Assumes a 32-bit AHB-Lite slave port with word-aligned registers.
package atpam_pkg;

   // Bus geometry
   localparam int          ADDR_W     = 12;
   localparam int          DATA_W     = 32;
   localparam int          REG_W      = 8;
   localparam logic [2:0]  HSIZE_WORD = 3'h2;
   localparam logic [1:0]  HRESP_OKAY = 2'h0;

   // Register indices; byte address is four times the index
   localparam int PS_CTRL_IDX   = 32'h40;
   localparam int TRIM_IDX      = 32'h42;
   localparam int LIVE_IDX      = 32'h43;
   localparam int IRQ_STS_IDX   = 32'h44;
   localparam int IRQ_MASK_IDX  = 32'h45;

   localparam logic [ADDR_W-1:0] PS_CTRL_ADDR  = ADDR_W'(PS_CTRL_IDX * 4);
   localparam logic [ADDR_W-1:0] TRIM_ADDR     = ADDR_W'(TRIM_IDX * 4);
   localparam logic [ADDR_W-1:0] LIVE_ADDR     = ADDR_W'(LIVE_IDX * 4);
   localparam logic [ADDR_W-1:0] IRQ_STS_ADDR  = ADDR_W'(IRQ_STS_IDX * 4);
   localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = ADDR_W'(IRQ_MASK_IDX * 4);

   // Reset values
   localparam logic [REG_W-1:0] TRIM_RST     = 8'h00;
   localparam logic [2:0]       PS_CTRL_RST  = 3'h0;
   localparam logic [4:0]       ALARM_RST    = 5'h1F;
   localparam logic [4:0]       IRQ_RST      = 5'h00;

   // Live status layout: flags in bits 6..2, fixed ones elsewhere
   localparam int              LIVE_LSB     = 2;
   localparam int              LIVE_MSB     = 6;
   localparam logic [REG_W-1:0] LIVE_FIXED  = 8'h83;
   // Power-save control layout; bit 3 is the read-only validity flag
   localparam int              PS_VALID_BIT = 3;
   localparam int              NUM_ALARM    = 5;

   // Pump comparator flags, active low, in register bit order 6..2
   typedef struct packed {
      logic high_pump_overvolt1_live_n;
      logic high_pump_overvolt2_live_n;
      logic high_pump_undervolt_live_n;
      logic low_pump_overvolt_live_n;
      logic low_pump_undervolt_live_n;
   } atpam_alarm_t;

   // Power-save controls, active low
   typedef struct packed {
      logic pump_power_save_n;
      logic pump_regulator_power_save_n;
      logic global_power_save_n;
   } atpam_ps_t;

   // Captured address phase
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic              write;
   } atpam_aphase_t;

   typedef enum logic [1:0] {
      BUS_IDLE,
      BUS_WRITE,
      BUS_READ_WAIT,
      BUS_READ_DONE
   } atpam_bus_state_t;

endpackage : atpam_pkg

//--- hdl/atpam_top.sv
// Amplifier trim register and live charge-pump alarm monitor, AHB-Lite slave.
// Assumes one clock; comparator flags arrive asynchronously from analogue.
`timescale 1ns/1ns
module atpam_top
   import atpam_pkg::*;
(
   // Clock and reset
   input  wire logic              CLK_SYS_I,
   input  wire logic              RST_N_I,
   // AHB-Lite slave
   input  wire logic              HSEL_I,
   input  wire logic [ADDR_W-1:0] HADDR_I,
   input  wire logic [1:0]        HTRANS_I,
   input  wire logic              HWRITE_I,
   input  wire logic [2:0]        HSIZE_I,
   input  wire logic [DATA_W-1:0] HWDATA_I,
   input  wire logic              HREADY_I,
   output logic                   HREADYOUT_O,
   output logic      [DATA_W-1:0] HRDATA_O,
   output logic      [1:0]        HRESP_O,
   // Analogue side
   input  wire atpam_alarm_t      PUMP_ALARM_LIVE_N_I,
   output logic      [REG_W-1:0]  CURRENT_AMP_TRIM_O,
   output atpam_ps_t              POWER_SAVE_N_O,
   output logic                   PUMP_ALARM_VALID_O,
   // Interrupt
   output logic                   IRQ_O
);

   // Bus state and captured address phase
   atpam_bus_state_t    state_reg;
   atpam_bus_state_t    state_next;
   atpam_aphase_t       aphase_reg;
   logic [DATA_W-1:0]   hrdata_reg;

   // Registers
   logic [REG_W-1:0]    trim_reg;
   atpam_ps_t           ps_reg;
   logic [4:0]          irq_sts_reg;
   logic [4:0]          irq_sts_next;
   logic [4:0]          irq_mask_reg;

   // Three-stage synchroniser and filtered flags
   logic [4:0]          sync1_reg;
   logic [4:0]          sync2_reg;
   logic [4:0]          sync3_reg;
   logic [4:0]          live_reg;
   wire  [4:0]          live_next;

   // Decode
   wire                 accept;
   wire                 wr_en;
   wire                 wr_trim;
   wire                 wr_ps;
   wire                 wr_sts;
   wire                 wr_mask;
   wire                 pump_valid;
   wire [4:0]           alarm_event;
   wire [REG_W-1:0]     live_word;
   wire [REG_W-1:0]     ps_word;
   wire [REG_W-1:0]     rd_mux;

   assign accept  = HSEL_I & HREADY_I & HTRANS_I[1];
   assign wr_en   = (state_reg == BUS_WRITE);
   assign wr_trim = wr_en & (aphase_reg.addr == TRIM_ADDR);
   assign wr_ps   = wr_en & (aphase_reg.addr == PS_CTRL_ADDR);
   assign wr_sts  = wr_en & (aphase_reg.addr == IRQ_STS_ADDR);
   assign wr_mask = wr_en & (aphase_reg.addr == IRQ_MASK_ADDR);

   // Flags mean nothing unless every power-save control is released
   assign pump_valid = &ps_reg;

   // Unlatched view with fixed ones around the five flags
   assign live_word = LIVE_FIXED | {1'b0, live_reg, 2'b00};
   assign ps_word   = {4'h0, pump_valid, ps_reg};

   // Unmapped addresses read as zero; the live register has no write path
   assign rd_mux =
      (aphase_reg.addr == TRIM_ADDR)     ? trim_reg :
      (aphase_reg.addr == LIVE_ADDR)     ? live_word :
      (aphase_reg.addr == PS_CTRL_ADDR)  ? ps_word :
      (aphase_reg.addr == IRQ_STS_ADDR)  ? {3'h0, irq_sts_reg} :
      (aphase_reg.addr == IRQ_MASK_ADDR) ? {3'h0, irq_mask_reg} :
      8'h00;

   // Bus sequencing: writes take no wait, reads take one
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         BUS_IDLE, BUS_WRITE, BUS_READ_DONE: begin
            if (accept) begin
               state_next = HWRITE_I ? BUS_WRITE : BUS_READ_WAIT;
            end else begin
               state_next = BUS_IDLE;
            end
         end
         BUS_READ_WAIT: begin
            state_next = BUS_READ_DONE;
         end
         default: begin
            state_next = BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         state_reg  <= BUS_IDLE;
         aphase_reg <= '0;
         hrdata_reg <= '0;
      end else begin
         state_reg <= state_next;
         if (accept) begin
            aphase_reg <= '{addr: HADDR_I, write: HWRITE_I};
         end
         if (state_reg == BUS_READ_WAIT) begin
            hrdata_reg <= {{(DATA_W-REG_W){1'b0}}, rd_mux};
         end
      end
   end

   assign HREADYOUT_O = (state_reg != BUS_READ_WAIT);
   assign HRDATA_O    = hrdata_reg;
   assign HRESP_O     = HRESP_OKAY;

   // Software registers
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         trim_reg     <= TRIM_RST;
         ps_reg       <= PS_CTRL_RST;
         irq_mask_reg <= IRQ_RST;
      end else begin
         if (wr_trim) begin
            trim_reg <= HWDATA_I[REG_W-1:0];
         end
         if (wr_ps) begin
            ps_reg <= HWDATA_I[2:0];
         end
         if (wr_mask) begin
            irq_mask_reg <= HWDATA_I[4:0];
         end
      end
   end

   assign CURRENT_AMP_TRIM_O = trim_reg;
   assign POWER_SAVE_N_O     = ps_reg;
   assign PUMP_ALARM_VALID_O = pump_valid;

   // Comparator inputs cross in; a change counts once stages two and three agree
   generate
      for (genvar i = 0; i < NUM_ALARM; i++) begin : g_sync
         always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
            if (!RST_N_I) begin
               sync1_reg[i] <= ALARM_RST[i];
               sync2_reg[i] <= ALARM_RST[i];
               sync3_reg[i] <= ALARM_RST[i];
            end else begin
               sync1_reg[i] <= PUMP_ALARM_LIVE_N_I[i];
               sync2_reg[i] <= sync1_reg[i];
               sync3_reg[i] <= sync2_reg[i];
            end
         end
         // Follows the comparator both ways; a flag holds only while stages two and three disagree
         assign live_next[i] = (sync2_reg[i] == sync3_reg[i]) ?
                               sync3_reg[i] : live_reg[i];
      end
   endgenerate

   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         live_reg <= ALARM_RST;
      end else begin
         live_reg <= live_next;
      end
   end

   // A flag dropping to zero while valid is an event; raw glitches
   // during power-up are hidden because validity is still low
   assign alarm_event = live_reg & ~live_next & {NUM_ALARM{pump_valid}};

   // Write one to clear; a new event in the same cycle wins
   assign irq_sts_next = (irq_sts_reg & ~({NUM_ALARM{wr_sts}} & HWDATA_I[4:0]))
                         | alarm_event;

   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         irq_sts_reg <= IRQ_RST;
      end else begin
         irq_sts_reg <= irq_sts_next;
      end
   end

   assign IRQ_O = |(irq_sts_reg & irq_mask_reg);

   // Checks
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (!RST_N_I);

   chk_trim_write: assert property (
      wr_trim |=> (CURRENT_AMP_TRIM_O == $past(HWDATA_I[REG_W-1:0])))
      else $error("trim register did not take written value");

   chk_trim_hold: assert property (
      !wr_trim |=> $stable(CURRENT_AMP_TRIM_O))
      else $error("trim register changed without a write");

   chk_flag_polarity: assert property (
      (sync2_reg == sync3_reg) |=> (live_reg == $past(sync3_reg)))
      else $error("live flag does not follow comparator level");

   chk_valid_gate: assert property (
      PUMP_ALARM_VALID_O == (POWER_SAVE_N_O == 3'h7))
      else $error("validity not tied to all power-save bits");

   chk_event_valid: assert property (
      (irq_sts_reg & ~$past(irq_sts_reg)) != 5'h00 |-> $past(pump_valid))
      else $error("alarm event captured while flags invalid");

   chk_no_latch: assert property (
      (sync3_reg[0] && sync2_reg[0]) [*2] |=> live_reg[0])
      else $error("cleared alarm flag did not return to one");

   chk_flag_layout: assert property (
      live_word[LIVE_MSB:LIVE_LSB] == live_reg)
      else $error("live flags not in bits six to two");

   chk_fixed_bits: assert property (
      (state_reg == BUS_READ_WAIT && aphase_reg.addr == LIVE_ADDR)
      |=> (HRDATA_O[REG_W-1:0] & LIVE_FIXED) == LIVE_FIXED)
      else $error("unused live bits did not read as one");

   chk_irq_level: assert property (
      IRQ_O == ((irq_sts_reg & irq_mask_reg) != 5'h00))
      else $error("interrupt output disagrees with masked status");

   chk_read_wait: assert property (
      (accept && !HWRITE_I) |=> !HREADYOUT_O ##1 HREADYOUT_O)
      else $error("read did not take exactly one wait state");

   chk_trim_readback: assert property (
      (state_reg == BUS_READ_WAIT && aphase_reg.addr == TRIM_ADDR)
      |=> HRDATA_O[REG_W-1:0] == $past(trim_reg))
      else $error("trim read did not return the register");

   chk_live_readback: assert property (
      (state_reg == BUS_READ_WAIT && aphase_reg.addr == LIVE_ADDR)
      |=> HRDATA_O[REG_W-1:0] == $past(live_word))
      else $error("live read did not return current flags");

   chk_ps_write: assert property (
      wr_ps |=> (POWER_SAVE_N_O == $past(HWDATA_I[2:0])))
      else $error("power-save controls did not take written value");

   chk_ps_hold: assert property (
      !wr_ps |=> $stable(POWER_SAVE_N_O))
      else $error("power-save controls changed without a write");

   chk_valid_readback: assert property (
      ps_word[PS_VALID_BIT] == PUMP_ALARM_VALID_O)
      else $error("validity bit does not match validity output");

   chk_mask_write: assert property (
      wr_mask |=> (irq_mask_reg == $past(HWDATA_I[4:0])))
      else $error("interrupt mask did not take written value");

   chk_event_sets: assert property (
      (alarm_event != 5'h00) |=> ((irq_sts_reg & $past(alarm_event)) == $past(alarm_event)))
      else $error("alarm event did not set its status bit");

   chk_sts_sticky: assert property (
      !wr_sts |=> ((irq_sts_reg & $past(irq_sts_reg)) == $past(irq_sts_reg)))
      else $error("status bit dropped without a clear");

   chk_sts_clear: assert property (
      (wr_sts && alarm_event == 5'h00)
      |=> ((irq_sts_reg & $past(HWDATA_I[4:0])) == 5'h00))
      else $error("written one did not clear status bit");

   chk_rdata_upper: assert property (
      HRDATA_O[DATA_W-1:REG_W] == '0)
      else $error("read data above the register width not zero");

   chk_resp_okay: assert property (
      HRESP_O == HRESP_OKAY)
      else $error("bus response other than okay");

   chk_write_nowait: assert property (
      (accept && HWRITE_I) |=> HREADYOUT_O)
      else $error("write data phase inserted a wait state");

   cov_trim_write: cover property (wr_trim);
   cov_live_read: cover property (
      state_reg == BUS_READ_WAIT && aphase_reg.addr == LIVE_ADDR);
   cov_alarm_irq: cover property ($rose(IRQ_O));
   cov_flag_recover: cover property (pump_valid && $rose(live_reg[2]));
   cov_sts_clear: cover property (wr_sts && irq_sts_reg != 5'h00);

endmodule : atpam_top

//--- verification/amp_trim_and_pump_alarm_monitor_tb.sv
// Self-checking bench for the amplifier-trim and pump-alarm register bank.
// Assumes this bench is the only AHB-Lite master and the block the only slave.
`timescale 1ns/1ns
module amp_trim_and_pump_alarm_monitor_tb
   import atpam_pkg::*;
;
   logic                clk;
   logic                rst_n;
   logic                hsel;
   logic                hwrite;
   logic [1:0]          htrans;
   logic [ADDR_W-1:0]   haddr;
   logic [2:0]          hsize;
   logic [DATA_W-1:0]   hwdata;
   atpam_alarm_t        alarm_n;
   wire logic           hready;
   wire logic           irq;
   wire logic           valid;
   wire logic [DATA_W-1:0] hrdata;
   wire logic [1:0]     hresp;
   wire logic [REG_W-1:0] trim;
   atpam_ps_t           ps_n;
   int                  fails;
   int                  checks;
   int                  trim_m;
   int                  ps_m;
   int                  mask_m;
   int                  sts_m;
   int                  polls;
   logic [31:0]         rnd;
   logic [31:0]         rd;
   logic [31:0]         wd;

   atpam_top u_atpam_top (
      .CLK_SYS_I           (clk),
      .RST_N_I             (rst_n),
      .HSEL_I              (hsel),
      .HADDR_I             (haddr),
      .HTRANS_I            (htrans),
      .HWRITE_I            (hwrite),
      .HSIZE_I             (hsize),
      .HWDATA_I            (hwdata),
      .HREADY_I            (hready),
      .HREADYOUT_O         (hready),
      .HRDATA_O            (hrdata),
      .HRESP_O             (hresp),
      .PUMP_ALARM_LIVE_N_I (alarm_n),
      .CURRENT_AMP_TRIM_O  (trim),
      .POWER_SAVE_N_O      (ps_n),
      .PUMP_ALARM_VALID_O  (valid),
      .IRQ_O               (irq)
   );

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : report_and_stop

   // Bounded wait so a stuck wait state ends the run instead of hanging
   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hready !== 1'b1 && n < 50);
      if (hready !== 1'b1) begin
         chk("hready timeout", hready, 1'b1);
         report_and_stop();
      end
   endtask : wait_rdy

   task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= wr;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      rd = hrdata;
      hsel <= 1'b0;
      #1;
   endtask : bus

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial begin
      rst_n   = 1'b0;
      hsel    = 1'b0;
      htrans  = 2'h0;
      haddr   = '0;
      hwrite  = 1'b0;
      hsize   = HSIZE_WORD;
      hwdata  = '0;
      alarm_n = '1;
      fails   = 0;
      checks  = 0;
      rnd     = 32'hBC400D4A;
      sts_m   = 0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      bus(1'b0, TRIM_ADDR, 32'h0);
      chk("trim reset", rd, 32'h00);
      chk("bus response", hresp, HRESP_OKAY);
      bus(1'b0, LIVE_ADDR, 32'h0);
      chk("live reset", rd, 32'hFF);
      $display("test reset done");
      // First write is the over-current setting, the rest random
      for (int i = 0; i < 6; i++) begin
         rnd = lfsr(rnd);
         wd = (i == 0) ? 32'h20 : rnd;
         trim_m = wd[7:0];
         bus(1'b1, TRIM_ADDR, wd);
         chk("trim port", trim, trim_m);
         bus(1'b0, TRIM_ADDR, 32'h0);
         chk("trim read", rd, trim_m);
      end
      bus(1'b1, 12'h104, 32'hFF);
      bus(1'b0, 12'h104, 32'h0);
      chk("unmapped", rd, 32'h0);
      bus(1'b1, LIVE_ADDR, 32'h0);
      bus(1'b0, LIVE_ADDR, 32'h0);
      chk("live write", rd, 32'hFF);
      $display("test trim done");
      mask_m = 32'h15;
      bus(1'b1, IRQ_MASK_ADDR, mask_m);
      // Second pass leaves the pump power-save low, so flags stay raw but no events
      for (int p = 0; p < 2; p++) begin
         ps_m = (p == 0) ? 7 : 3;
         bus(1'b1, PS_CTRL_ADDR, ps_m);
         chk("valid", valid, ps_m == 7);
         chk("ps port", ps_n, ps_m);
         bus(1'b0, PS_CTRL_ADDR, 32'h0);
         chk("ps read", rd, (ps_m == 7) ? 32'hF : ps_m);
         // Hold off the alarm sweep until the pump reports settled
         polls = 0;
         do begin
            bus(1'b0, LIVE_ADDR, 32'h0);
            polls++;
         end while (rd[LIVE_MSB:LIVE_LSB] !== 5'h1F && polls < 20);
         chk("pump settled", rd, 32'hFF);
         for (int i = 0; i < NUM_ALARM; i++) begin
            @(posedge clk);
            alarm_n <= 5'h1F ^ (5'h01 << i);
            repeat (8) @(posedge clk);
            if (ps_m == 7)
               sts_m = sts_m | (1 << i);
            bus(1'b0, LIVE_ADDR, 32'h0);
            chk("live low", rd, 32'h83 | ((32'h1F ^ (32'h1 << i)) << 2));
            chk("irq set", irq, (sts_m & mask_m) != 0);
            @(posedge clk);
            alarm_n <= '1;
            repeat (8) @(posedge clk);
            bus(1'b0, LIVE_ADDR, 32'h0);
            chk("live back", rd, 32'hFF);
            bus(1'b0, IRQ_STS_ADDR, 32'h0);
            chk("status", rd, sts_m);
            bus(1'b1, IRQ_STS_ADDR, sts_m);
            sts_m = 0;
            chk("irq clear", irq, 1'b0);
         end
      end
      $display("test alarms done");
      report_and_stop();
   end
endmodule : amp_trim_and_pump_alarm_monitor_tb
